// ==== fpshs_defs.svh ====
`ifndef FPSHS_DEFS_SVH
`define FPSHS_DEFS_SVH

// Primary and extended opcodes
`define FPSHS_OP_FS_UPD       6'h35
`define FPSHS_OP_EXT          6'h1f
`define FPSHS_OP_HALF         6'h2c
`define FPSHS_XO_FS_UPD_IDX   10'h2b7
`define FPSHS_XO_FS_IDX       10'h297
`define FPSHS_XO_HALF_REV     10'h396

// Field positions, little-endian bit numbers of the instruction word
`define FPSHS_PRI_HI          31
`define FPSHS_PRI_LO          26
`define FPSHS_SRC_HI          25
`define FPSHS_SRC_LO          21
`define FPSHS_BASE_HI         20
`define FPSHS_BASE_LO         16
`define FPSHS_IDX_HI          15
`define FPSHS_IDX_LO          11
`define FPSHS_XO_HI           10
`define FPSHS_XO_LO           1
`define FPSHS_DISP_HI         15
`define FPSHS_DISP_LO         0

// Double to single conversion thresholds (biased double exponent)
`define FPSHS_EXP_SGL_MIN     11'h380
`define FPSHS_EXP_DENORM_MIN  11'h36a
`define FPSHS_EXP_SHIFT_BASE  11'h381

// Reset values
`define FPSHS_RST_WORD        32'h0000_0000
`define FPSHS_RST_REG         5'h00

`endif

// ==== fpshs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpshs_mem_model (
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_b_i,
	// Store port and fault control
	input  wire fpshs_pkg::fpshs_store_t store_i,
	input  wire logic [3:0]              delay_i,
	input  wire logic [1:0]              flt_i,
	output logic                         ack_o,
	output logic                         align_o,
	output logic                         storage_o
);
	logic [3:0] cnt;
	logic       tgl;
	// Fault lines are meaningless without ack, so they wander
	assign align_o = ack_o ? flt_i[1] : tgl;
	assign storage_o = ack_o ? flt_i[0] : ~tgl;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 4'h0;
			ack_o <= 1'b0;
			tgl <= 1'b0;
		end else begin
			tgl <= ~tgl;
			ack_o <= 1'b0;
			if (store_i.valid && !ack_o) begin
				if (cnt == delay_i) begin
					ack_o <= 1'b1;
					cnt <= 4'h0;
				end else begin
					cnt <= cnt + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== fpshs_pkg.sv ====
`default_nettype none
package fpshs_pkg;

	typedef enum logic [1:0] {
		FPSHS_IDLE = 2'b00,
		FPSHS_READ = 2'b01,
		FPSHS_MEM  = 2'b11,
		FPSHS_WB   = 2'b10
	} fpshs_state_t;

	typedef enum logic [2:0] {
		FPSHS_K_NONE       = 3'h0,
		FPSHS_K_FS_UPD     = 3'h1,
		FPSHS_K_FS_UPD_IDX = 3'h2,
		FPSHS_K_FS_IDX     = 3'h3,
		FPSHS_K_HALF       = 3'h4,
		FPSHS_K_HALF_REV   = 3'h5
	} fpshs_kind_t;

	typedef struct packed {
		fpshs_kind_t kind;
		logic [4:0]  src_field;
		logic [4:0]  base_reg_field;
		logic [4:0]  index_reg_field;
		logic [15:0] disp;
	} fpshs_op_t;

	// One store toward memory; data of a halfword sits in [15:0], [15:8] at the lower address
	typedef struct packed {
		logic        valid;
		logic        is_half;
		logic [31:0] effective_address;
		logic [31:0] data;
	} fpshs_store_t;

	typedef struct packed {
		logic        en;
		logic [4:0]  addr;
		logic [31:0] data;
	} fpshs_gpr_wr_t;

endpackage
`default_nettype wire

// ==== fpshs_unit.sv ====
// Notes on behaviour
// - Primary opcode 53 is float single store with update, displacement form.
// - Opcode 31, extended 695 is float single store with update, indexed.
// - Opcode 31, extended 663 is float single indexed store, no update.
// - Primary opcode 44 is halfword store, displacement form.
// - Opcode 31, extended 918 is byte-reversed indexed halfword store.
// - Float stores convert the register to single and store one word.
// - Displacement sign-extended; added to base unless base field is zero.
// - Indexed address is base plus index, or index alone when base field zero.
// - Update forms write address to nonzero base only without alignment/storage fault.
// - Float stores leave float status and condition field 0 untouched.
// - Halfword stores write the low sixteen source bits.
// - Byte-reversed store swaps the two bytes of that halfword.
// - Halfword stores leave fixed-point exception and condition field 0 untouched.
`timescale 1ns/1ps
`default_nettype none
`include "fpshs_defs.svh"

module fpshs_unit (
	// Clock and reset
	input  wire logic                    sys_clk_i,
	input  wire logic                    rst_b_i,
	// Instruction issue
	input  wire logic                    issue_valid_i,
	input  wire logic [31:0]             issue_instr_i,
	output logic                         issue_ready_o,
	output logic                         done_o,
	output logic                         unknown_o,
	output logic                         fault_o,
	// Register file read, data valid in the same cycle as the address
	output logic [4:0]                   gpr_rd_a_addr_o,
	output logic [4:0]                   gpr_rd_b_addr_o,
	input  wire logic [31:0]             gpr_rd_a_data_i,
	input  wire logic [31:0]             gpr_rd_b_data_i,
	output logic [4:0]                   fpr_rd_addr_o,
	input  wire logic [63:0]             fpr_rd_data_i,
	// Base register write-back
	output fpshs_pkg::fpshs_gpr_wr_t     gpr_wr_o,
	// Memory store port
	output fpshs_pkg::fpshs_store_t      store_o,
	input  wire logic                    store_ack_i,
	input  wire logic                    align_fault_i,
	input  wire logic                    storage_fault_i
);

	fpshs_pkg::fpshs_state_t  state;
	fpshs_pkg::fpshs_state_t  next_state;
	fpshs_pkg::fpshs_op_t     op;
	fpshs_pkg::fpshs_op_t     next_op;
	fpshs_pkg::fpshs_store_t  next_store;
	fpshs_pkg::fpshs_gpr_wr_t next_gpr_wr;
	logic                     next_issue_ready;
	logic                     next_done;
	logic                     next_unknown;
	logic                     next_fault;
	logic [4:0]               next_gpr_rd_a_addr;
	logic [4:0]               next_gpr_rd_b_addr;
	logic [4:0]               next_fpr_rd_addr;
	fpshs_pkg::fpshs_op_t     dec;
	logic [31:0]              addr_calc;

	function automatic fpshs_pkg::fpshs_op_t decode(input logic [31:0] ins);
		fpshs_pkg::fpshs_op_t d;
		logic [5:0]           pri;
		logic [9:0]           xo;
		pri = ins[`FPSHS_PRI_HI:`FPSHS_PRI_LO];
		xo = ins[`FPSHS_XO_HI:`FPSHS_XO_LO];
		d.src_field = ins[`FPSHS_SRC_HI:`FPSHS_SRC_LO];
		d.base_reg_field = ins[`FPSHS_BASE_HI:`FPSHS_BASE_LO];
		d.index_reg_field = ins[`FPSHS_IDX_HI:`FPSHS_IDX_LO];
		d.disp = ins[`FPSHS_DISP_HI:`FPSHS_DISP_LO];
		d.kind = fpshs_pkg::FPSHS_K_NONE;
		// Bit 0 is never looked at for the indexed forms
		if (pri == `FPSHS_OP_FS_UPD) begin
			d.kind = fpshs_pkg::FPSHS_K_FS_UPD;
		end else if (pri == `FPSHS_OP_HALF) begin
			d.kind = fpshs_pkg::FPSHS_K_HALF;
		end else if (pri == `FPSHS_OP_EXT) begin
			case (xo)
				`FPSHS_XO_FS_UPD_IDX: d.kind = fpshs_pkg::FPSHS_K_FS_UPD_IDX;
				`FPSHS_XO_FS_IDX:     d.kind = fpshs_pkg::FPSHS_K_FS_IDX;
				`FPSHS_XO_HALF_REV:   d.kind = fpshs_pkg::FPSHS_K_HALF_REV;
				default:              d.kind = fpshs_pkg::FPSHS_K_NONE;
			endcase
		end
		return d;
	endfunction

	// Double to single rounding is truncation, as the store conversion demands no rounding
	function automatic logic [31:0] to_single(input logic [63:0] dbl);
		logic [10:0] exp;
		logic [52:0] mant;
		logic [10:0] sh;
		logic [31:0] w;
		exp = dbl[62:52];
		mant = {1'b1, dbl[51:0]};
		sh = 11'h000;
		w = {dbl[63:62], dbl[58:29]};
		if (exp <= `FPSHS_EXP_SGL_MIN && exp >= `FPSHS_EXP_DENORM_MIN) begin
			// Too small for a normal single: denormalise into the fraction
			sh = `FPSHS_EXP_SHIFT_BASE - exp;
			mant = mant >> sh;
			w = {dbl[63], 8'h00, mant[51:29]};
		end
		return w;
	endfunction

	function automatic logic is_update(input fpshs_pkg::fpshs_kind_t k);
		return (k == fpshs_pkg::FPSHS_K_FS_UPD) || (k == fpshs_pkg::FPSHS_K_FS_UPD_IDX);
	endfunction

	function automatic logic is_half(input fpshs_pkg::fpshs_kind_t k);
		return (k == fpshs_pkg::FPSHS_K_HALF) || (k == fpshs_pkg::FPSHS_K_HALF_REV);
	endfunction

	function automatic logic is_disp(input fpshs_pkg::fpshs_kind_t k);
		return (k == fpshs_pkg::FPSHS_K_FS_UPD) || (k == fpshs_pkg::FPSHS_K_HALF);
	endfunction

	assign dec = decode(issue_instr_i);

	always_comb begin
		logic [31:0] offset;
		logic [31:0] base;
		// Base field zero means the value zero, not register zero
		base = (op.base_reg_field == 5'h00) ? 32'h0000_0000 : gpr_rd_a_data_i;
		offset = gpr_rd_b_data_i;
		if (is_disp(op.kind)) begin
			offset = {{16{op.disp[15]}}, op.disp};
		end
		addr_calc = base + offset;
	end

	always_comb begin
		next_state = state;
		next_op = op;
		next_store = store_o;
		next_gpr_wr = gpr_wr_o;
		next_issue_ready = issue_ready_o;
		next_done = 1'b0;
		next_unknown = 1'b0;
		next_fault = 1'b0;
		next_gpr_rd_a_addr = gpr_rd_a_addr_o;
		next_gpr_rd_b_addr = gpr_rd_b_addr_o;
		next_fpr_rd_addr = fpr_rd_addr_o;
		next_gpr_wr.en = 1'b0;
		case (state)
			fpshs_pkg::FPSHS_IDLE: begin
				if (issue_valid_i && issue_ready_o) begin
					if (dec.kind == fpshs_pkg::FPSHS_K_NONE) begin
						next_unknown = 1'b1;
						next_done = 1'b1;
					end else begin
						next_op = dec;
						next_gpr_rd_a_addr = dec.base_reg_field;
						// Halfword source comes from port B in displacement form
						next_gpr_rd_b_addr = is_disp(dec.kind) ? dec.src_field : dec.index_reg_field;
						next_fpr_rd_addr = dec.src_field;
						next_issue_ready = 1'b0;
						next_state = fpshs_pkg::FPSHS_READ;
					end
				end
			end
			fpshs_pkg::FPSHS_READ: begin
				next_store.valid = 1'b1;
				next_store.effective_address = addr_calc;
				next_store.is_half = is_half(op.kind);
				if (op.kind == fpshs_pkg::FPSHS_K_HALF_REV) begin
					next_store.data = {16'h0000, gpr_rd_b_data_i[7:0], gpr_rd_b_data_i[15:8]};
				end else if (is_half(op.kind)) begin
					next_store.data = {16'h0000, gpr_rd_b_data_i[15:0]};
				end else begin
					next_store.data = to_single(fpr_rd_data_i);
				end
				// Indexed halfwords need a third read unless the index field is the source field; source reread on port B
				if (op.kind == fpshs_pkg::FPSHS_K_HALF_REV && gpr_rd_b_addr_o != op.src_field) begin
					next_store.valid = 1'b0;
					next_op.disp = addr_calc[15:0];
					next_gpr_wr.data = addr_calc;
					next_gpr_rd_b_addr = op.src_field;
					next_state = fpshs_pkg::FPSHS_WB;
				end else begin
					next_gpr_wr.data = addr_calc;
					next_state = fpshs_pkg::FPSHS_MEM;
				end
			end
			fpshs_pkg::FPSHS_WB: begin
				// Source now readable; address was kept from the first pass
				next_store.valid = 1'b1;
				next_store.effective_address = gpr_wr_o.data;
				next_store.is_half = 1'b1;
				next_store.data = {16'h0000, gpr_rd_b_data_i[7:0], gpr_rd_b_data_i[15:8]};
				next_state = fpshs_pkg::FPSHS_MEM;
			end
			fpshs_pkg::FPSHS_MEM: begin
				if (store_ack_i) begin
					next_store.valid = 1'b0;
					next_done = 1'b1;
					next_fault = align_fault_i || storage_fault_i;
					next_issue_ready = 1'b1;
					next_state = fpshs_pkg::FPSHS_IDLE;
					// Address write-back only; no status or condition register port exists
					if (is_update(op.kind) && op.base_reg_field != 5'h00
						&& !align_fault_i && !storage_fault_i) begin
						next_gpr_wr.en = 1'b1;
						next_gpr_wr.addr = op.base_reg_field;
					end
				end
			end
			default: begin
				next_state = fpshs_pkg::FPSHS_IDLE;
				next_issue_ready = 1'b1;
				next_store.valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= fpshs_pkg::FPSHS_IDLE;
			op <= '0;
			store_o <= '0;
			gpr_wr_o <= '0;
			issue_ready_o <= 1'b1;
			done_o <= 1'b0;
			unknown_o <= 1'b0;
			fault_o <= 1'b0;
			gpr_rd_a_addr_o <= `FPSHS_RST_REG;
			gpr_rd_b_addr_o <= `FPSHS_RST_REG;
			fpr_rd_addr_o <= `FPSHS_RST_REG;
		end else begin
			state <= next_state;
			op <= next_op;
			store_o <= next_store;
			gpr_wr_o <= next_gpr_wr;
			issue_ready_o <= next_issue_ready;
			done_o <= next_done;
			unknown_o <= next_unknown;
			fault_o <= next_fault;
			gpr_rd_a_addr_o <= next_gpr_rd_a_addr;
			gpr_rd_b_addr_o <= next_gpr_rd_b_addr;
			fpr_rd_addr_o <= next_fpr_rd_addr;
		end
	end

endmodule

`default_nettype wire

// ==== fpshs_unit_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpshs_unit_asserts (
	// Clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_b_i,
	// Issue
	input  wire logic                     issue_valid_i,
	input  wire logic [31:0]              issue_instr_i,
	input  wire logic                     issue_ready_o,
	input  wire logic                     done_o,
	input  wire logic                     unknown_o,
	input  wire logic                     fault_o,
	// Write-back and memory
	input  wire fpshs_pkg::fpshs_gpr_wr_t gpr_wr_o,
	input  wire fpshs_pkg::fpshs_store_t  store_o,
	input  wire logic                     store_ack_i,
	input  wire logic                     align_fault_i,
	input  wire logic                     storage_fault_i
);
	logic       tk;
	logic [5:0] op;
	assign tk = issue_valid_i && issue_ready_o;
	assign op = issue_instr_i[31:26];
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	a_fsu_word: assert property (tk && op == 6'h35 |-> ##2 store_o.valid && !store_o.is_half)
		else $error("float store word late");
	a_fsux_word: assert property (tk && op == 6'h1f && issue_instr_i[10:1] == 10'h2b7
		|-> ##2 store_o.valid && !store_o.is_half) else $error("indexed float store late");
	a_half_kind: assert property (tk && op == 6'h2c |-> ##2 store_o.valid && store_o.is_half)
		else $error("halfword store late");
	a_rev_half: assert property (tk && op == 6'h1f && issue_instr_i[10:1] == 10'h396
		|-> ##[2:3] store_o.valid && store_o.is_half) else $error("reversed halfword store late");
	a_unknown_op: assert property (tk && op == 6'h34 |=> done_o && unknown_o && !fault_o)
		else $error("unknown opcode not dropped");
	a_store_hold: assert property (store_o.valid && !store_ack_i |=> $stable(store_o))
		else $error("store changed before ack");
	a_ack_done: assert property (store_o.valid && store_ack_i |=> done_o && !store_o.valid)
		else $error("no done after ack");
	a_fault_nowb: assert property (store_o.valid && store_ack_i && (align_fault_i ||
		storage_fault_i) |=> fault_o && !gpr_wr_o.en) else $error("update after fault");
	a_wb_addr: assert property (gpr_wr_o.en |-> gpr_wr_o.addr != 5'h00 && done_o &&
		gpr_wr_o.data == $past(store_o.effective_address)) else $error("bad write-back");
	a_done_ready: assert property (done_o |-> issue_ready_o)
		else $error("not ready at done");
endmodule
bind fpshs_unit fpshs_unit_asserts chk_u (.sys_clk_i, .rst_b_i, .issue_valid_i,
	.issue_instr_i, .issue_ready_o, .done_o, .unknown_o, .fault_o, .gpr_wr_o, .store_o,
	.store_ack_i, .align_fault_i, .storage_fault_i);
`default_nettype wire

// ==== fpshs_unit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module fpshs_unit_tb;
	logic                     sys_clk_i = 1'h0;
	logic                     rst_b_i = 1'h0;
	logic                     issue_valid_i = 1'h0;
	logic [31:0]              issue_instr_i = 32'h0;
	logic                     issue_ready_o, done_o, unknown_o, fault_o, ack, al, st;
	logic [4:0]               ra, rb, fr;
	fpshs_pkg::fpshs_gpr_wr_t gpr_wr_o;
	fpshs_pkg::fpshs_store_t  store_o;
	logic [3:0]               dly = 4'h0;
	logic [1:0]               flt = 2'h0;
	logic [63:0]              fpr_val = 64'h4865_6c6c_6f20_776f;
	int                       error_cnt = 0;
	int                       cmp_count = 0;
	int                       cyc = 0;
	fpshs_unit dut_u (.sys_clk_i, .rst_b_i, .issue_valid_i, .issue_instr_i, .issue_ready_o,
		.done_o, .unknown_o, .fault_o, .gpr_rd_a_addr_o(ra), .gpr_rd_b_addr_o(rb),
		.gpr_rd_a_data_i(32'h9000_3400 | {27'h0, ra}), .gpr_rd_b_data_i(32'h9000_3400 | {27'h0, rb}),
		.fpr_rd_addr_o(fr), .fpr_rd_data_i(fr == 5'h06 ? fpr_val : 64'h0), .gpr_wr_o, .store_o,
		.store_ack_i(ack), .align_fault_i(al), .storage_fault_i(st));
	fpshs_mem_model mem_u (.clk_i(sys_clk_i), .rst_b_i, .store_i(store_o), .delay_i(dly),
		.flt_i(flt), .ack_o(ack), .align_o(al), .storage_o(st));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic run_op(input logic [31:0] ins, a, d, input logic h, w, f,
		input logic [3:0] dl, input logic [1:0] fl);
		int n;
		@(posedge sys_clk_i);
		issue_valid_i <= 1'h1;
		issue_instr_i <= ins;
		dly <= dl;
		flt <= fl;
		@(posedge sys_clk_i);
		issue_valid_i <= 1'h0;
		n = 0;
		while (store_o.valid !== 1'h1 && n < 20) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		`CHK("addr", a, store_o.effective_address)
		`CHK("half", h, store_o.is_half)
		`CHK("data", d, h ? {16'h0, store_o.data[15:0]} : store_o.data)
		n = 0;
		while (done_o !== 1'h1 && n < 20) begin
			@(posedge sys_clk_i);
			#1;
			n++;
		end
		`CHK("wb", w, gpr_wr_o.en)
		`CHK("fault", f, fault_o)
		if (w) `CHK("wbaddr", ins[20:16], gpr_wr_o.addr)
		if (w) `CHK("wbdata", a, gpr_wr_o.data)
	endtask
	task automatic t_fs_denorm();
		@(posedge sys_clk_i);
		fpr_val <= 64'h3800_0000_0000_0000;
		run_op({6'h35, 5'h06, 5'h00, 16'h0010}, 32'h0000_0010, 32'h0040_0000, 1'h0, 1'h0, 1'h0, 4'h0, 2'h0);
		@(posedge sys_clk_i);
		fpr_val <= 64'hb6a0_0000_0000_0000;
		run_op({6'h1f, 5'h06, 5'h00, 5'h07, 10'h297, 1'h0}, 32'h9000_3407, 32'h8000_0001, 1'h0, 1'h0, 1'h0, 4'h0, 2'h0);
	endtask
	task automatic t_fs_upd();
		run_op({6'h35, 5'h06, 5'h04, 16'hfff0}, 32'h9000_33f4, 32'h432b_6363, 1'h0, 1'h1, 1'h0, 4'h0, 2'h0);
		run_op({6'h35, 5'h06, 5'h00, 16'h8000}, 32'hffff_8000, 32'h432b_6363, 1'h0, 1'h0, 1'h0, 4'h3, 2'h0);
	endtask
	task automatic t_fs_upd_idx();
		run_op({6'h1f, 5'h06, 5'h05, 5'h04, 10'h2b7, 1'h0}, 32'h2000_6809, 32'h432b_6363, 1'h0, 1'h1, 1'h0, 4'h1, 2'h0);
		run_op({6'h1f, 5'h06, 5'h05, 5'h04, 10'h2b7, 1'h0}, 32'h2000_6809, 32'h432b_6363, 1'h0, 1'h0, 1'h1, 4'h0, 2'h2);
	endtask
	task automatic t_fs_idx();
		run_op({6'h1f, 5'h06, 5'h00, 5'h07, 10'h297, 1'h1}, 32'h9000_3407, 32'h432b_6363, 1'h0, 1'h0, 1'h1, 4'h2, 2'h1);
	endtask
	task automatic t_half();
		run_op({6'h2c, 5'h06, 5'h00, 16'h7ffe}, 32'h0000_7ffe, 32'h0000_3406, 1'h1, 1'h0, 1'h0, 4'h0, 2'h0);
	endtask
	task automatic t_half_rev();
		run_op({6'h1f, 5'h06, 5'h04, 5'h09, 10'h396, 1'h0}, 32'h2000_680d, 32'h0000_0634, 1'h1, 1'h0, 1'h0, 4'h0, 2'h0);
		run_op({6'h1f, 5'h06, 5'h04, 5'h06, 10'h396, 1'h1}, 32'h2000_680a, 32'h0000_0634, 1'h1, 1'h0, 1'h0, 4'h1, 2'h0);
	endtask
	task automatic t_unknown();
		@(posedge sys_clk_i);
		issue_valid_i <= 1'h1;
		issue_instr_i <= {6'h34, 5'h06, 5'h04, 16'h0010};
		@(posedge sys_clk_i);
		issue_valid_i <= 1'h0;
		#1;
		`CHK("unknown", 2'h3, {done_o, unknown_o})
		`CHK("nostore", 1'h0, store_o.valid)
	endtask
	initial begin
		repeat (5) @(posedge sys_clk_i);
		rst_b_i <= 1'h1;
		t_fs_upd();
		t_fs_upd_idx();
		t_fs_idx();
		t_half();
		t_half_rev();
		t_fs_denorm();
		t_unknown();
		report_and_stop();
	end
endmodule
`default_nettype wire
